//--- verilog/fos_top.sv
`timescale 1ns/1ps
`include "fos_map.svh"
module fos_top
	import fos_pkg::*;
#(
	parameter fos_cnt_t SIDE_PERIOD_CYC = fos_cnt_t'(`FOS_SIDE_PERIOD_CYC),
	parameter fos_cnt_t SIDE_LOW_CYC = fos_cnt_t'(`FOS_SIDE_LOW_CYC),
	parameter fos_cnt_t PULSE_PERIOD_CYC = fos_cnt_t'(`FOS_PULSE_PERIOD_CYC),
	parameter fos_cnt_t PULSE_LOW_CYC = fos_cnt_t'(`FOS_PULSE_LOW_CYC)
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wake_event,
	input wire logic failure_event,
	input wire logic int_pin_rx,
	output logic int_pin_tx,
	output logic int_pin_oe,
	input wire logic side_indicator_out_rx,
	output logic side_indicator_out_tx,
	output logic side_indicator_out_oe,
	input wire logic pulsed_light_or_dev_strap_rx,
	output logic pulsed_light_or_dev_strap_tx,
	output logic pulsed_light_or_dev_strap_oe,
	output logic config_13_sel,
	output logic dev_mode
);
	// pin index: 0 interrupt, 1 side indicator, 2 pulsed light / strap
	logic [2:0] sync1_q, sync2_q, sync3_q, lvl_q, lvl_d;
	fos_state_e state_q, state_d;
	logic [2:0] settle_q, settle_d;
	logic cfg13_q, cfg13_d, dev_q, dev_d;
	logic [1:0] fail_ctrl_q, fail_ctrl_d, gpio_out_q, gpio_out_d, event_q, event_d;
	logic [3:0] gpio_ctrl_q, gpio_ctrl_d;
	logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d;
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0] waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic wstrb0_q, wstrb0_d;
	logic int_tx_q, int_tx_d, int_oe_q, int_oe_d;
	logic side_tx_q, side_tx_d, side_oe_q, side_oe_d;
	logic pulse_tx_q, pulse_tx_d, pulse_oe_q, pulse_oe_d;
	logic do_write, run, wake_set;
	fos_pin_mode_e mode_one, mode_two;
	fos_blink_if bl ();

	// address decode shared by both bus paths
	function automatic logic mapped(input logic [7:0] a);
		if (a == `FOS_ADDR_FAIL_CTRL) mapped = 1'b1;
		else if (a == `FOS_ADDR_GPIO_CTRL) mapped = 1'b1;
		else if (a == `FOS_ADDR_GPIO_OUT) mapped = 1'b1;
		else if (a == `FOS_ADDR_EVENT) mapped = 1'b1;
		else if (a == `FOS_ADDR_STATUS) mapped = 1'b1;
		else mapped = 1'b0;
	endfunction

	// drive of one reconfigurable pin as {tx, oe}; open drain pulls low with oe high
	function automatic logic [1:0] pin_drive(input fos_pin_mode_e mode, input logic fail_low,
		input logic out_bit);
		case (mode)
			FOS_MODE_FAIL: pin_drive = {1'b0, fail_low};
			FOS_MODE_LOW_SIDE: pin_drive = {1'b0, out_bit};
			FOS_MODE_HIGH_SIDE: pin_drive = {1'b1, out_bit};
			default: pin_drive = 2'b00;
		endcase
	endfunction

	fos_blink #(
		.SIDE_PERIOD(SIDE_PERIOD_CYC),
		.SIDE_LOW(SIDE_LOW_CYC),
		.PULSE_PERIOD(PULSE_PERIOD_CYC),
		.PULSE_LOW(PULSE_LOW_CYC)
	) u_blink (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.bl(bl)
	);

	// pin filter and strap capture; a level counts once stages two and three agree
	always_comb begin
		lvl_d = lvl_q;
		for (int i = 0; i < 3; i++) begin
			if (sync2_q[i] == sync3_q[i]) begin
				lvl_d[i] = sync3_q[i];
			end
		end
		state_d = state_q;
		settle_d = settle_q;
		cfg13_d = cfg13_q;
		dev_d = dev_q;
		case (state_q)
			FOS_ST_SENSE: begin
				if (settle_q == `FOS_STRAP_SETTLE) begin
					state_d = FOS_ST_RUN;
					cfg13_d = lvl_q[0];
					dev_d = !lvl_q[2];
				end else begin
					settle_d = settle_q + 3'h1;
				end
			end
			default: state_d = FOS_ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
			sync3_q <= 3'h7;
			lvl_q <= 3'h7;
			state_q <= FOS_ST_SENSE;
			settle_q <= 3'h0;
			cfg13_q <= 1'b0;
			dev_q <= 1'b0;
		end else if (ce) begin
			sync1_q <= {pulsed_light_or_dev_strap_rx, side_indicator_out_rx, int_pin_rx};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			lvl_q <= lvl_d;
			state_q <= state_d;
			settle_q <= settle_d;
			cfg13_q <= cfg13_d;
			dev_q <= dev_d;
		end
	end

	assign run = (state_q == FOS_ST_RUN);
	assign mode_one = fos_pin_mode_e'(gpio_ctrl_q[1:0]);
	assign mode_two = fos_pin_mode_e'(gpio_ctrl_q[3:2]);
	assign bl.side_en = run && mode_one == FOS_MODE_FAIL && fail_ctrl_q[`FOS_FC_SIDE_EN];
	assign bl.pulse_en = run && mode_two == FOS_MODE_FAIL && fail_ctrl_q[`FOS_FC_PULSE_EN];
	// any filtered change on a pin in wake mode is a wake event
	assign wake_set = wake_event
		|| (run && mode_one == FOS_MODE_WAKE && lvl_d[1] != lvl_q[1])
		|| (run && mode_two == FOS_MODE_WAKE && lvl_d[2] != lvl_q[2]);
	assign do_write = aw_full_q && w_full_q && !bvalid_q;

	// bus slave and registers; write and read paths are independent
	always_comb begin
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb0_d = wstrb0_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		fail_ctrl_d = fail_ctrl_q;
		gpio_ctrl_d = gpio_ctrl_q;
		gpio_out_d = gpio_out_q;
		event_d = event_q;
		if (s_axi_awvalid && awready_q) begin
			aw_full_d = 1'b1;
			waddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_full_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb0_d = s_axi_wstrb[0];
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (do_write) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = mapped(waddr_q) ? `FOS_RESP_OKAY : `FOS_RESP_SLVERR;
			if (wstrb0_q) begin
				if (waddr_q == `FOS_ADDR_FAIL_CTRL) begin
					fail_ctrl_d = wdata_q[1:0];
				end else if (waddr_q == `FOS_ADDR_GPIO_CTRL) begin
					gpio_ctrl_d = wdata_q[3:0];
				end else if (waddr_q == `FOS_ADDR_GPIO_OUT) begin
					gpio_out_d = wdata_q[1:0];
				end else if (waddr_q == `FOS_ADDR_EVENT) begin
					event_d = event_q & ~wdata_q[1:0];
				end
			end
		end
		// hardware set wins over a same-cycle clear
		if (wake_set) event_d[`FOS_EV_WAKE] = 1'b1;
		if (failure_event) event_d[`FOS_EV_FAIL] = 1'b1;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d = mapped(s_axi_araddr) ? `FOS_RESP_OKAY : `FOS_RESP_SLVERR;
			if (s_axi_araddr == `FOS_ADDR_FAIL_CTRL) begin
				rdata_d = {30'h0, fail_ctrl_q};
			end else if (s_axi_araddr == `FOS_ADDR_GPIO_CTRL) begin
				rdata_d = {28'h0, gpio_ctrl_q};
			end else if (s_axi_araddr == `FOS_ADDR_GPIO_OUT) begin
				rdata_d = {30'h0, gpio_out_q};
			end else if (s_axi_araddr == `FOS_ADDR_EVENT) begin
				rdata_d = {30'h0, event_q};
			end else if (s_axi_araddr == `FOS_ADDR_STATUS) begin
				rdata_d = {28'h0, lvl_q[2], lvl_q[1], dev_q, cfg13_q};
			end else begin
				rdata_d = 32'h0;
			end
		end
		awready_d = !aw_full_d;
		wready_d = !w_full_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			waddr_q <= 8'h0;
			wdata_q <= 32'h0;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `FOS_RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= `FOS_RESP_OKAY;
			rdata_q <= 32'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			arready_q <= 1'b0;
			fail_ctrl_q <= `FOS_FAIL_CTRL_RST;
			gpio_ctrl_q <= `FOS_GPIO_CTRL_RST;
			gpio_out_q <= `FOS_GPIO_OUT_RST;
			event_q <= `FOS_EVENT_RST;
		end else if (ce) begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb0_q <= wstrb0_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
			fail_ctrl_q <= fail_ctrl_d;
			gpio_ctrl_q <= gpio_ctrl_d;
			gpio_out_q <= gpio_out_d;
			event_q <= event_d;
		end
	end

	// pin drivers; pins stay released while straps are sensed so pull levels read true
	always_comb begin
		int_oe_d = run;
		int_tx_d = !(|event_q);
		{side_tx_d, side_oe_d} = 2'b00;
		{pulse_tx_d, pulse_oe_d} = 2'b00;
		if (run) begin
			{side_tx_d, side_oe_d} = pin_drive(mode_one, bl.side_low, gpio_out_q[0]);
			{pulse_tx_d, pulse_oe_d} = pin_drive(mode_two, bl.pulse_low, gpio_out_q[1]);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			int_tx_q <= 1'b1;
			int_oe_q <= 1'b0;
			side_tx_q <= 1'b0;
			side_oe_q <= 1'b0;
			pulse_tx_q <= 1'b0;
			pulse_oe_q <= 1'b0;
		end else if (ce) begin
			int_tx_q <= int_tx_d;
			int_oe_q <= int_oe_d;
			side_tx_q <= side_tx_d;
			side_oe_q <= side_oe_d;
			pulse_tx_q <= pulse_tx_d;
			pulse_oe_q <= pulse_oe_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign int_pin_tx = int_tx_q;
	assign int_pin_oe = int_oe_q;
	assign side_indicator_out_tx = side_tx_q;
	assign side_indicator_out_oe = side_oe_q;
	assign pulsed_light_or_dev_strap_tx = pulse_tx_q;
	assign pulsed_light_or_dev_strap_oe = pulse_oe_q;
	assign config_13_sel = cfg13_q;
	assign dev_mode = dev_q;
endmodule

//--- verilog/fos_map.svh
// Notes on behaviour
// - interrupt pin low flags wake or failure
// - interrupt pin strap picks configuration 1/3 or 2/4
// - side indicator blinks 1.25Hz, 50% low
// - pulsed light pulses 100Hz, 20% low
// - grounded test strap selects development mode
// - open or high strap selects normal operation
// - fail pins reconfigurable as wake, low, high side
// - both pins default to fail output function
`ifndef FOS_MAP_SVH
`define FOS_MAP_SVH

`define FOS_ADDR_FAIL_CTRL 8'h00
`define FOS_ADDR_GPIO_CTRL 8'h04
`define FOS_ADDR_GPIO_OUT 8'h08
`define FOS_ADDR_EVENT 8'h0c
`define FOS_ADDR_STATUS 8'h10

`define FOS_FC_SIDE_EN 0
`define FOS_FC_PULSE_EN 1
`define FOS_EV_WAKE 0
`define FOS_EV_FAIL 1
`define FOS_ST_CFG13 0
`define FOS_ST_DEV 1
`define FOS_ST_LVL_ONE 2
`define FOS_ST_LVL_TWO 3

`define FOS_FAIL_CTRL_RST 2'h0
`define FOS_GPIO_CTRL_RST 4'h0
`define FOS_GPIO_OUT_RST 2'h0
`define FOS_EVENT_RST 2'h0

`define FOS_RESP_OKAY 2'h0
`define FOS_RESP_SLVERR 2'h2

// strap sampling waits until the synchroniser and filter are full
`define FOS_STRAP_SETTLE 3'h5

// blink timing, frequencies in millihertz, duty in percent
`define FOS_CLK_HZ 64'd50000000
`define FOS_SIDE_FREQ_MHZ 64'd1250
`define FOS_SIDE_DUTY_PCT 64'd50
`define FOS_PULSE_FREQ_MHZ 64'd100000
`define FOS_PULSE_DUTY_PCT 64'd20
`define FOS_SIDE_PERIOD_CYC (`FOS_CLK_HZ * 64'd1000 / `FOS_SIDE_FREQ_MHZ)
`define FOS_SIDE_LOW_CYC (`FOS_SIDE_PERIOD_CYC * `FOS_SIDE_DUTY_PCT / 64'd100)
`define FOS_PULSE_PERIOD_CYC (`FOS_CLK_HZ * 64'd1000 / `FOS_PULSE_FREQ_MHZ)
`define FOS_PULSE_LOW_CYC (`FOS_PULSE_PERIOD_CYC * `FOS_PULSE_DUTY_PCT / 64'd100)

`endif

//--- verilog/fos_pkg.sv
package fos_pkg;
	typedef logic [25:0] fos_cnt_t;

	typedef enum logic [1:0] {
		FOS_MODE_FAIL = 2'b00,
		FOS_MODE_WAKE = 2'b01,
		FOS_MODE_LOW_SIDE = 2'b10,
		FOS_MODE_HIGH_SIDE = 2'b11
	} fos_pin_mode_e;

	typedef enum logic [0:0] {
		FOS_ST_SENSE = 1'b0,
		FOS_ST_RUN = 1'b1
	} fos_state_e;
endpackage

//--- verilog/fos_blink_if.sv
`timescale 1ns/1ps
// enables toward the pattern generator, active-low phases back
interface fos_blink_if;
	logic side_en;
	logic pulse_en;
	logic side_low;
	logic pulse_low;
	modport ctl (output side_en, output pulse_en, input side_low, input pulse_low);
	modport gen (input side_en, input pulse_en, output side_low, output pulse_low);
endinterface

//--- verilog/fos_blink.sv
`timescale 1ns/1ps
module fos_blink
	import fos_pkg::*;
#(
	parameter fos_cnt_t SIDE_PERIOD = 26'h1,
	parameter fos_cnt_t SIDE_LOW = 26'h1,
	parameter fos_cnt_t PULSE_PERIOD = 26'h1,
	parameter fos_cnt_t PULSE_LOW = 26'h1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	fos_blink_if.gen bl
);
	fos_cnt_t side_cnt_q, side_cnt_d, pulse_cnt_q, pulse_cnt_d;

	// wraps at the period; held at zero while disabled so each burst starts low
	function automatic fos_cnt_t next_count(input fos_cnt_t cnt, input fos_cnt_t period,
		input logic en);
		if (!en || cnt >= period - 26'h1) begin
			next_count = '0;
		end else begin
			next_count = cnt + 26'h1;
		end
	endfunction

	// counters and low phases
	always_comb begin
		side_cnt_d = next_count(side_cnt_q, SIDE_PERIOD, bl.side_en);
		pulse_cnt_d = next_count(pulse_cnt_q, PULSE_PERIOD, bl.pulse_en);
		bl.side_low = bl.side_en && (side_cnt_q < SIDE_LOW);
		bl.pulse_low = bl.pulse_en && (pulse_cnt_q < PULSE_LOW);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			side_cnt_q <= '0;
			pulse_cnt_q <= '0;
		end else if (ce) begin
			side_cnt_q <= side_cnt_d;
			pulse_cnt_q <= pulse_cnt_d;
		end
	end
endmodule

//--- verif/fos_load.sv
`timescale 1ns/1ps
// host strap resistors and lamp loads around the pins
module fos_load (
	input wire logic int_pull,
	input wire logic test_gnd,
	input wire logic ext_low,
	input wire logic int_tx,
	input wire logic int_oe,
	input wire logic side_tx,
	input wire logic side_oe,
	input wire logic pl_tx,
	input wire logic pl_oe,
	output logic int_rx,
	output logic side_rx,
	output logic pl_rx
);
	// undriven int pin shows the strap: pull-up, else weak pull-down
	assign int_rx = int_oe ? int_tx : int_pull;
	// lamp load pulls up unless the pin or a switch sinks it
	assign side_rx = !((side_oe && !side_tx) || ext_low);
	// integrated pull-up wins unless the strap is grounded or the pin sinks it
	assign pl_rx = !((pl_oe && !pl_tx) || test_gnd);
endmodule

//--- verif/fos_top_props.sv
`timescale 1ns/1ps
module fos_top_props
	import fos_pkg::*;
#(
	parameter fos_cnt_t SIDE_LOW_CYC = 26'h1,
	parameter fos_cnt_t PULSE_LOW_CYC = 26'h1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wake_event,
	input wire logic failure_event,
	input wire logic int_pin_rx,
	input wire logic int_pin_tx,
	input wire logic int_pin_oe,
	input wire logic side_indicator_out_tx,
	input wire logic side_indicator_out_oe,
	input wire logic pulsed_light_or_dev_strap_rx,
	input wire logic pulsed_light_or_dev_strap_tx,
	input wire logic pulsed_light_or_dev_strap_oe,
	input wire logic config_13_sel,
	input wire logic dev_mode
);
	logic side_lo, pl_lo;
	fos_cnt_t side_cnt_q, side_cnt_d, pl_cnt_q, pl_cnt_d;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// open-drain sink only; high-side drive is not a blink phase
	assign side_lo = side_indicator_out_oe && !side_indicator_out_tx;
	assign pl_lo = pulsed_light_or_dev_strap_oe && !pulsed_light_or_dev_strap_tx;
	// length of the current sink stretch
	always_comb begin
		side_cnt_d = side_lo ? side_cnt_q + 26'h1 : 26'h0;
		pl_cnt_d = pl_lo ? pl_cnt_q + 26'h1 : 26'h0;
	end
	// cleared in reset so a stale run never meets a fresh blink
	always_ff @(posedge sys_clk) begin
		side_cnt_q <= rst_n ? side_cnt_d : 26'h0;
		pl_cnt_q <= rst_n ? pl_cnt_d : 26'h0;
	end
	// end of a sink phase, then the released part of the period
	sequence s_side_end;
		$past(rst_n) && $fell(side_lo);
	endsequence
	sequence s_side_gap;
		(!side_indicator_out_oe)[*8] ##1 side_indicator_out_oe;
	endsequence
	sequence s_pl_end;
		$past(rst_n) && $fell(pl_lo);
	endsequence
	sequence s_pl_gap;
		(!pulsed_light_or_dev_strap_oe)[*8] ##1 pulsed_light_or_dev_strap_oe;
	endsequence
	AST_EVENT_INT: assert property ((wake_event || failure_event) |-> ##2 !int_pin_tx)
		else $error("int pin not low after event");
	AST_QUIET_START: assert property ($rose(rst_n) |-> !int_pin_oe && !side_indicator_out_oe
		&& !pulsed_light_or_dev_strap_oe && !config_13_sel && !dev_mode)
		else $error("pins or strap outputs active right after reset");
	AST_STRAP_SEL: assert property ($rose(int_pin_oe) |-> config_13_sel == $past(int_pin_rx, 6)
		&& dev_mode == !$past(pulsed_light_or_dev_strap_rx, 6))
		else $error("strap selection differs from pin levels");
	AST_STRAP_HOLD: assert property ($past(rst_n) && $past(int_pin_oe) |->
		$stable(config_13_sel) && $stable(dev_mode))
		else $error("strap selection changed after latch");
	AST_SIDE_LOW: assert property (s_side_end |-> side_cnt_q == SIDE_LOW_CYC)
		else $error("side indicator low phase length wrong");
	AST_SIDE_GAP: assert property (s_side_end |-> s_side_gap)
		else $error("side indicator released phase length wrong");
	AST_PULSE_LOW: assert property (s_pl_end |-> pl_cnt_q == PULSE_LOW_CYC)
		else $error("pulsed light low phase length wrong");
	AST_PULSE_GAP: assert property (s_pl_end |-> s_pl_gap)
		else $error("pulsed light released phase length wrong");
endmodule

bind fos_top fos_top_props #(.SIDE_LOW_CYC(SIDE_LOW_CYC), .PULSE_LOW_CYC(PULSE_LOW_CYC))
	i_fos_top_props (.sys_clk(sys_clk), .rst_n(rst_n), .wake_event(wake_event),
	.failure_event(failure_event), .int_pin_rx(int_pin_rx), .int_pin_tx(int_pin_tx),
	.int_pin_oe(int_pin_oe), .side_indicator_out_tx(side_indicator_out_tx),
	.side_indicator_out_oe(side_indicator_out_oe),
	.pulsed_light_or_dev_strap_rx(pulsed_light_or_dev_strap_rx),
	.pulsed_light_or_dev_strap_tx(pulsed_light_or_dev_strap_tx),
	.pulsed_light_or_dev_strap_oe(pulsed_light_or_dev_strap_oe),
	.config_13_sel(config_13_sel), .dev_mode(dev_mode));

//--- verif/fos_top_tb.sv
`timescale 1ns/1ps
module fos_top_tb;
	import fos_pkg::*;
	logic sys_clk;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic wake_event = 1'b0, failure_event = 1'b0;
	logic int_pull = 1'b1, test_gnd = 1'b1, ext_low = 1'b0;
	logic int_pin_rx, int_pin_tx, int_pin_oe, config_13_sel, dev_mode;
	logic side_indicator_out_rx, side_indicator_out_tx, side_indicator_out_oe;
	logic pulsed_light_or_dev_strap_rx, pulsed_light_or_dev_strap_tx, pulsed_light_or_dev_strap_oe;
	int num_checks = 0, bad_count = 0, cycles = 0, side_lows = 0, pl_lows = 0;

	// short blink counts: 16/8 and 10/2 keep 50 and 20 percent
	fos_top #(.SIDE_PERIOD_CYC(26'h10), .SIDE_LOW_CYC(26'h8), .PULSE_PERIOD_CYC(26'ha),
		.PULSE_LOW_CYC(26'h2)) i_fos_top (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .wake_event(wake_event), .failure_event(failure_event),
		.int_pin_rx(int_pin_rx), .int_pin_tx(int_pin_tx), .int_pin_oe(int_pin_oe),
		.side_indicator_out_rx(side_indicator_out_rx),
		.side_indicator_out_tx(side_indicator_out_tx),
		.side_indicator_out_oe(side_indicator_out_oe),
		.pulsed_light_or_dev_strap_rx(pulsed_light_or_dev_strap_rx),
		.pulsed_light_or_dev_strap_tx(pulsed_light_or_dev_strap_tx),
		.pulsed_light_or_dev_strap_oe(pulsed_light_or_dev_strap_oe),
		.config_13_sel(config_13_sel), .dev_mode(dev_mode));
	fos_load i_fos_load (.int_pull(int_pull), .test_gnd(test_gnd), .ext_low(ext_low),
		.int_tx(int_pin_tx), .int_oe(int_pin_oe), .side_tx(side_indicator_out_tx),
		.side_oe(side_indicator_out_oe), .pl_tx(pulsed_light_or_dev_strap_tx),
		.pl_oe(pulsed_light_or_dev_strap_oe), .int_rx(int_pin_rx),
		.side_rx(side_indicator_out_rx), .pl_rx(pulsed_light_or_dev_strap_rx));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		check("bresp", 32'h0, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		check("rdata", exp, s_axi_rdata);
		check("rresp", {30'h0, rexp}, {30'h0, s_axi_rresp});
		s_axi_rready <= 1'b0;
	endtask

	// straps change only while reset holds, then settle past the latch
	task automatic boot(input logic pull, input logic gnd);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		int_pull <= pull;
		test_gnd <= gnd;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge sys_clk);
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// hang guard, far above the few hundred cycles the tests need
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end

	initial begin
		boot(1'b1, 1'b1);
		check("config_13_sel", 32'h1, {31'h0, config_13_sel});
		check("dev_mode", 32'h1, {31'h0, dev_mode});
		check("int_pin_oe", 32'h1, {31'h0, int_pin_oe});
		rd(8'h10, 32'h7, 2'h0);
		boot(1'b0, 1'b0);
		int_pull <= 1'b1;
		test_gnd <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check("config_13_sel", 32'h0, {31'h0, config_13_sel});
		check("dev_mode", 32'h0, {31'h0, dev_mode});
		rd(8'h10, 32'h4, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h14, 32'h0, 2'h2);
		$display("test straps done");
		for (int i = 0; i < 2; i++) begin
			{failure_event, wake_event} <= 2'b01 << i;
			@(posedge sys_clk);
			{failure_event, wake_event} <= 2'b00;
			repeat (2) @(posedge sys_clk);
			check("int_pin_tx", 32'h0, {31'h0, int_pin_tx});
			rd(8'h0c, 32'h1 << i, 2'h0);
			wr(8'h0c, 32'h3);
			repeat (3) @(posedge sys_clk);
			check("int_pin_tx", 32'h1, {31'h0, int_pin_tx});
		end
		$display("test events done");
		// pin one high side, pin two low side left off
		wr(8'h08, 32'h1);
		wr(8'h04, 32'hb);
		repeat (3) @(posedge sys_clk);
		check("side tx oe", 32'h3, {30'h0, side_indicator_out_tx, side_indicator_out_oe});
		check("pulse tx oe", 32'h0, {30'h0, pulsed_light_or_dev_strap_tx,
			pulsed_light_or_dev_strap_oe});
		wr(8'h04, 32'h1);
		repeat (3) @(posedge sys_clk);
		check("side oe", 32'h0, {31'h0, side_indicator_out_oe});
		ext_low <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check("int_pin_tx", 32'h0, {31'h0, int_pin_tx});
		rd(8'h0c, 32'h1, 2'h0);
		ext_low <= 1'b0;
		repeat (8) @(posedge sys_clk);
		wr(8'h0c, 32'h3);
		// pin two senses wake; lifting the grounded strap gives it an edge
		wr(8'h04, 32'h4);
		test_gnd <= 1'b0;
		repeat (8) @(posedge sys_clk);
		check("int_pin_tx", 32'h0, {31'h0, int_pin_tx});
		rd(8'h0c, 32'h1, 2'h0);
		rd(8'h10, 32'hc, 2'h0);
		wr(8'h0c, 32'h3);
		// wake sensing off again before the pins go back to fail signalling
		wr(8'h04, 32'h0);
		$display("test pin modes done");
		wr(8'h00, 32'h3);
		repeat (4) @(posedge sys_clk);
		// 80 cycles hold whole periods of both patterns
		repeat (80) begin
			@(posedge sys_clk);
			side_lows += side_indicator_out_oe;
			pl_lows += pulsed_light_or_dev_strap_oe;
		end
		check("side low cycles", 32'd40, side_lows);
		check("pulse low cycles", 32'd16, pl_lows);
		$display("test blink done");
		report_and_stop();
	end
endmodule
